// ### rtl/cal_ctrl_pkg.sv
// Shared constants, layouts and types of the calibration trigger and low-power control block
package cal_ctrl_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h6A;
  localparam logic [7:0] IDX_PIN_CFG = 8'h6B;
  localparam logic [7:0] IDX_SOFT_TRIG = 8'h6C;
  localparam logic [7:0] IDX_LP = 8'h6E;
  localparam logic [7:0] IDX_GAIN = 8'h7A;
  localparam logic [7:0] IDX_BANDGAP = 8'h7C;
  localparam logic [7:0] IDX_TERM_A = 8'h7E;
  localparam logic [7:0] IDX_ENGINE = 8'h62;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h91;

  // Reset values
  localparam logic [2:0] PIN_CFG_RST = 3'h0;
  localparam logic SOFT_TRIG_RST = 1'h1;
  localparam logic [7:0] LP_RST = 8'h88;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [3:0] BANDGAP_RST = 4'h0;
  localparam logic [7:0] TERM_A_RST = 8'h00;
  localparam logic ENGINE_RST = 1'h0;

  // Interrupt status and mask bit positions
  localparam int IRQ_FOREGROUND_COMPLETE_FLAG = 0;
  localparam int IRQ_STOPPED = 1;
  localparam int IRQ_LP_CAL = 2;
  localparam int IRQ_ALARM = 3;
  localparam int IRQ_W = 4;

  // Delays in device clock periods, as programmed by the sleep and wake codes
  localparam logic [40:0] SLEEP_PERIODS_0 = 41'h00000000480;
  localparam logic [40:0] SLEEP_PERIODS_1 = 41'h00000400080;
  localparam logic [40:0] SLEEP_PERIODS_2 = 41'h00002000080;
  localparam logic [40:0] SLEEP_PERIODS_3 = 41'h00010000080;
  localparam logic [40:0] SLEEP_PERIODS_4 = 41'h00080000080;
  localparam logic [40:0] SLEEP_PERIODS_5 = 41'h00400000080;
  localparam logic [40:0] SLEEP_PERIODS_6 = 41'h02000000080;
  localparam logic [40:0] SLEEP_PERIODS_7 = 41'h10000000080;
  localparam logic [40:0] WAKE_PERIODS_0 = 41'h00000000480;
  localparam logic [40:0] WAKE_PERIODS_1 = 41'h00002000080;
  localparam logic [40:0] WAKE_PERIODS_2 = 41'h00010000080;
  localparam logic [40:0] WAKE_PERIODS_3 = 41'h00080000080;
  // hclk is the device clock, so one period is one cycle
  localparam logic [40:0] PERIODS_PER_CYCLE = 41'h00000000001;

  typedef logic [7:0][40:0] sleep_table_type;
  typedef logic [3:0][40:0] wake_table_type;

  localparam sleep_table_type SLEEP_CYCLES_DEF = {
    SLEEP_PERIODS_7 / PERIODS_PER_CYCLE, SLEEP_PERIODS_6 / PERIODS_PER_CYCLE,
    SLEEP_PERIODS_5 / PERIODS_PER_CYCLE, SLEEP_PERIODS_4 / PERIODS_PER_CYCLE,
    SLEEP_PERIODS_3 / PERIODS_PER_CYCLE, SLEEP_PERIODS_2 / PERIODS_PER_CYCLE,
    SLEEP_PERIODS_1 / PERIODS_PER_CYCLE, SLEEP_PERIODS_0 / PERIODS_PER_CYCLE};
  localparam wake_table_type WAKE_CYCLES_DEF = {
    WAKE_PERIODS_3 / PERIODS_PER_CYCLE, WAKE_PERIODS_2 / PERIODS_PER_CYCLE,
    WAKE_PERIODS_1 / PERIODS_PER_CYCLE, WAKE_PERIODS_0 / PERIODS_PER_CYCLE};

  typedef enum logic [1:0] {
    STAT_SEL_FOREGROUND_COMPLETE_FLAG = 2'b00,
    STAT_SEL_STOPPED = 2'b01,
    STAT_SEL_ALARM = 2'b10,
    STAT_SEL_LOW = 2'b11
  } status_sel_type;

  typedef enum logic [1:0] {
    LP_IDLE = 2'b00,
    LP_SLEEP = 2'b01,
    LP_SETTLE = 2'b10,
    LP_CAL = 2'b11
  } lp_state_type;

  typedef struct packed {
    status_sel_type status_sel;
    logic hardware_trigger_select;
  } pin_cfg_type;

  typedef struct packed {
    logic [2:0] sleep_interval_code;
    logic [1:0] wake_settle_code;
    logic reserved;
    logic trigger_driven_sleep;
    logic lowpower_bgcal_enable;
  } lp_ctrl_type;

  typedef struct packed {
    logic [7:0] idx;
    logic write;
  } bus_phase_type;

endpackage

// ### rtl/lp_sequencer.sv
// Low-power background calibration sequencer for one offline converter core
`timescale 1ns/1ps
`default_nettype none
module lp_sequencer
  import cal_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic active,
  input wire logic trigger_driven_sleep,
  input wire logic trigger_level,
  input wire logic [40:0] sleep_cycles,
  input wire logic [40:0] wake_cycles,
  input wire logic core_offline,
  input wire logic lp_cal_done,
  output logic core_sleep,
  output logic core_cal_start,
  output lp_state_type state
);

  lp_state_type state_q;
  lp_state_type state_d;
  logic [40:0] count_q;
  logic sleep_q;
  logic start_q;
  wire logic sleep_end;
  wire logic settle_end;

  // timed sleep, sleep follows trigger level
  assign sleep_end = trigger_driven_sleep ? !trigger_level : (count_q == sleep_cycles - 41'h1);
  assign settle_end = (count_q == wake_cycles - 41'h1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      LP_IDLE: begin
        if (active && core_offline) begin
          state_d = LP_SLEEP;
        end
      end
      LP_SLEEP: begin
        if (sleep_end) begin
          state_d = LP_SETTLE;
        end
      end
      LP_SETTLE: begin
        if (settle_end) begin
          state_d = LP_CAL;
        end
      end
      LP_CAL: begin
        if (lp_cal_done) begin
          state_d = LP_IDLE;
        end
      end
      default: state_d = LP_IDLE;
    endcase
    // leaving low-power mode abandons the sequence
    if (!active) begin
      state_d = LP_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= LP_IDLE;
      count_q <= 41'h0;
      sleep_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= (state_d != state_q) ? 41'h0 : count_q + 41'h1;
      sleep_q <= (state_d == LP_SLEEP);
      start_q <= (state_q == LP_SETTLE) && (state_d == LP_CAL);
    end
  end

  assign core_sleep = sleep_q;
  assign core_cal_start = start_q;
  assign state = state_q;

  property p_trig_wake;
    @(posedge hclk) disable iff (!hresetn)
    (active && state_q == LP_SLEEP && trigger_driven_sleep && !trigger_level) |=> (state_q == LP_SETTLE);
  endproperty
  a_trig_wake: assert property (p_trig_wake) else $error("trigger low did not wake the core");

  property p_start_after_settle;
    @(posedge hclk) disable iff (!hresetn)
    $rose(core_cal_start) |-> $past(state_q) == LP_SETTLE && state_q == LP_CAL;
  endproperty
  a_start_after_settle: assert property (p_start_after_settle) else $error("calibration start without settling");

  property p_timed_sleep;
    @(posedge hclk) disable iff (!hresetn)
    (active && state_q == LP_SLEEP && !trigger_driven_sleep && count_q < sleep_cycles - 41'h1) |=> (state_q == LP_SLEEP || !$past(active));
  endproperty
  a_timed_sleep: assert property (p_timed_sleep) else $error("timed sleep ended early");

endmodule
`default_nettype wire

// ### rtl/cal_trigger_lowpower_ctrl.sv
// Calibration trigger selection, status pin, low-power sleep control and trim registers on AHB-Lite
// Summary of operation
// - Status-select picks pin source: foreground done, stopped, alarm, or constant low.
// - Trigger-source bit 0: trigger comes from software bit, hardware pin ignored.
// - Trigger-source bit 1: trigger follows hardware pin, software bit ignored.
// - Sleep code 0..7 selects the documented sleep interval in device clocks.
// - Wake code 0..3 selects settling time before a woken core calibrates.
// - Trigger-mode bit 0: sleep length comes from the sleep code only.
// - Trigger-mode bit 1: cores sleep while trigger high, wake when low.
// - Low-power enable resets to 0 and acts only with background calibration on.
// - Eight-bit gain trim adjusts all cores; range belongs to range control.
// - Four-bit band-gap trim holds factory value, stays readable and writable.
// - Gain trim loads its start value from the fuse store.
// - Foreground-done flag reads high once foreground calibration completed or skipped.
// - Stopped flag sets on halt, clears on resume; without background, on foreground done.
`timescale 1ns/1ps
`default_nettype none
module cal_trigger_lowpower_ctrl
  import cal_ctrl_pkg::*;
#(
  parameter sleep_table_type SLEEP_CYCLES = SLEEP_CYCLES_DEF,
  parameter wake_table_type WAKE_CYCLES = WAKE_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cal_trigger_input_pin,
  input wire logic alarm,
  input wire logic fg_cal_start,
  input wire logic fg_cal_done,
  input wire logic bg_cal_stopped,
  input wire logic bg_cal_resumed,
  input wire logic core_offline,
  input wire logic lp_cal_done,
  input wire logic fuse_load,
  input wire logic [7:0] fuse_gain,
  input wire logic [3:0] fuse_bandgap,
  input wire logic [7:0] fuse_term_a,
  output logic cal_state_output_pin,
  output logic cal_trigger,
  output logic background_cal_enable,
  output logic core_sleep,
  output logic core_cal_start,
  output logic [7:0] gain_trim,
  output logic [3:0] bandgap_trim,
  output logic [7:0] term_a_trim,
  output logic irq
);

  // Bus phase tracking
  bus_phase_type phase_q;
  logic wr_pend_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;

  // Registers
  pin_cfg_type pin_cfg_q;
  logic software_trigger_bit_q;
  lp_ctrl_type lp_q;
  logic [7:0] gain_q;
  logic [3:0] bandgap_q;
  logic [7:0] term_a_q;
  logic bg_enable_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_status_d;
  logic [IRQ_W-1:0] irq_mask_q;

  // Calibration state
  logic fg_flag_q;
  logic stopped_q;
  logic trig_q;
  logic pin_q;
  logic alarm_q;

  lp_state_type lp_state;
  wire logic lp_sleep;
  wire logic lp_start;

  // Address and write decode
  wire logic accept;
  wire logic [7:0] addr_idx;
  wire logic wr_pin;
  wire logic wr_soft;
  wire logic wr_lp;
  wire logic wr_gain;
  wire logic wr_bandgap;
  wire logic wr_term_a;
  wire logic wr_engine;
  wire logic wr_irq_status;
  wire logic wr_irq_mask;
  wire logic [IRQ_W-1:0] irq_set;
  wire logic [IRQ_W-1:0] irq_clr;
  wire logic lp_active;
  wire logic trig_sel;
  wire logic pin_d;
  wire logic stopped_set;
  wire logic [40:0] sleep_cycles;
  wire logic [40:0] wake_cycles;
  logic [31:0] rd_word;

  assign accept = hsel && htrans[1] && hready;
  assign addr_idx = haddr[9:2];
  assign wr_pin = wr_pend_q && phase_q.idx == IDX_PIN_CFG;
  assign wr_soft = wr_pend_q && phase_q.idx == IDX_SOFT_TRIG;
  assign wr_lp = wr_pend_q && phase_q.idx == IDX_LP;
  assign wr_gain = wr_pend_q && phase_q.idx == IDX_GAIN;
  assign wr_bandgap = wr_pend_q && phase_q.idx == IDX_BANDGAP;
  assign wr_term_a = wr_pend_q && phase_q.idx == IDX_TERM_A;
  assign wr_engine = wr_pend_q && phase_q.idx == IDX_ENGINE;
  assign wr_irq_status = wr_pend_q && phase_q.idx == IDX_IRQ_STATUS;
  assign wr_irq_mask = wr_pend_q && phase_q.idx == IDX_IRQ_MASK;

  // Zero wait states for writes; reads take one wait state so hrdata comes from a flop
  assign hreadyout = !rd_wait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= '0;
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= accept && hwrite;
      rd_wait_q <= accept && !hwrite;
      if (accept) begin
        phase_q <= '{idx: addr_idx, write: hwrite};
      end
      if (rd_wait_q) begin
        hrdata_q <= rd_word;
      end
    end
  end

  // Read mux; reserved bits and unmapped addresses read as zero
  always_comb begin
    rd_word = 32'h00000000;
    case (phase_q.idx)
      IDX_STATUS: rd_word[1:0] = {stopped_q, fg_flag_q};
      IDX_PIN_CFG: rd_word[2:0] = pin_cfg_q;
      IDX_SOFT_TRIG: rd_word[0] = software_trigger_bit_q;
      IDX_LP: rd_word[7:0] = lp_q;
      IDX_GAIN: rd_word[7:0] = gain_q;
      IDX_BANDGAP: rd_word[3:0] = bandgap_q;
      IDX_TERM_A: rd_word[7:0] = term_a_q;
      IDX_ENGINE: rd_word[0] = bg_enable_q;
      IDX_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status_q;
      IDX_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_q;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Control registers; reserved bits are not stored, writes to them are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_cfg_q <= PIN_CFG_RST;
      software_trigger_bit_q <= SOFT_TRIG_RST;
      lp_q <= LP_RST;
      bg_enable_q <= ENGINE_RST;
      irq_mask_q <= '0;
    end else begin
      if (wr_pin) begin
        pin_cfg_q <= hwdata[2:0];
      end
      if (wr_soft) begin
        software_trigger_bit_q <= hwdata[0];
      end
      if (wr_lp) begin
        lp_q <= {hwdata[7:3], 1'b0, hwdata[1:0]};
      end
      if (wr_engine) begin
        bg_enable_q <= hwdata[0];
      end
      if (wr_irq_mask) begin
        irq_mask_q <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // trims take the fuse values when the fuse store delivers them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_q <= GAIN_RST;
      bandgap_q <= BANDGAP_RST;
      term_a_q <= TERM_A_RST;
    end else if (fuse_load) begin
      gain_q <= fuse_gain;
      bandgap_q <= fuse_bandgap;
      term_a_q <= fuse_term_a;
    end else begin
      if (wr_gain) begin
        gain_q <= hwdata[7:0];
      end
      if (wr_bandgap) begin
        bandgap_q <= hwdata[3:0];
      end
      if (wr_term_a) begin
        term_a_q <= hwdata[7:0];
      end
    end
  end

  assign gain_trim = gain_q;
  assign bandgap_trim = bandgap_q;
  assign term_a_trim = term_a_q;
  assign background_cal_enable = bg_enable_q;

  assign trig_sel = pin_cfg_q.hardware_trigger_select ? cal_trigger_input_pin : software_trigger_bit_q;

  // without background calibration, foreground completion also counts as stopped
  assign stopped_set = bg_cal_stopped || (fg_cal_done && !bg_enable_q);

  assign pin_d = (pin_cfg_q.status_sel == STAT_SEL_FOREGROUND_COMPLETE_FLAG) ? fg_flag_q :
                 (pin_cfg_q.status_sel == STAT_SEL_STOPPED) ? stopped_q :
                 (pin_cfg_q.status_sel == STAT_SEL_ALARM) ? alarm : 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_q <= 1'b0;
      fg_flag_q <= 1'b0;
      stopped_q <= 1'b0;
      pin_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      // registered so a source switch cannot glitch the sequencer
      trig_q <= trig_sel;
      // done flag, a new foreground run clears it
      fg_flag_q <= fg_cal_done || (fg_flag_q && !fg_cal_start);
      stopped_q <= stopped_set || (stopped_q && !bg_cal_resumed);
      pin_q <= pin_d;
      alarm_q <= alarm;
    end
  end

  assign cal_trigger = trig_q;
  assign cal_state_output_pin = pin_q;

  // low-power mode needs background calibration too
  assign lp_active = lp_q.lowpower_bgcal_enable && bg_enable_q;
  assign sleep_cycles = SLEEP_CYCLES[lp_q.sleep_interval_code];
  assign wake_cycles = WAKE_CYCLES[lp_q.wake_settle_code];

  lp_sequencer u_lp_sequencer (
    .hclk(hclk),
    .hresetn(hresetn),
    .active(lp_active),
    .trigger_driven_sleep(lp_q.trigger_driven_sleep),
    .trigger_level(trig_q),
    .sleep_cycles(sleep_cycles),
    .wake_cycles(wake_cycles),
    .core_offline(core_offline),
    .lp_cal_done(lp_cal_done),
    .core_sleep(lp_sleep),
    .core_cal_start(lp_start),
    .state(lp_state)
  );

  assign core_sleep = lp_sleep;
  assign core_cal_start = lp_start;

  // Sticky interrupt sources; a set in the same cycle as a write-one-to-clear wins
  assign irq_set = {alarm && !alarm_q, lp_start, stopped_set, fg_cal_done};
  assign irq_clr = wr_irq_status ? hwdata[IRQ_W-1:0] : '0;

  always_comb begin
    irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq <= |(irq_status_d & irq_mask_q);
    end
  end

  property p_soft_source;
    @(posedge hclk) disable iff (!hresetn)
    !pin_cfg_q.hardware_trigger_select |=> cal_trigger == $past(software_trigger_bit_q);
  endproperty
  a_soft_source: assert property (p_soft_source) else $error("trigger not from software bit");

  property p_hw_source;
    @(posedge hclk) disable iff (!hresetn)
    pin_cfg_q.hardware_trigger_select |=> cal_trigger == $past(cal_trigger_input_pin);
  endproperty
  a_hw_source: assert property (p_hw_source) else $error("trigger not from hardware pin");

  property p_status_low;
    @(posedge hclk) disable iff (!hresetn)
    pin_cfg_q.status_sel == STAT_SEL_LOW |=> !cal_state_output_pin;
  endproperty
  a_status_low: assert property (p_status_low) else $error("status pin not held low");

  property p_status_alarm;
    @(posedge hclk) disable iff (!hresetn)
    pin_cfg_q.status_sel == STAT_SEL_ALARM |=> cal_state_output_pin == $past(alarm);
  endproperty
  a_status_alarm: assert property (p_status_alarm) else $error("status pin does not follow alarm");

  property p_foreground_complete_flag;
    @(posedge hclk) disable iff (!hresetn)
    fg_cal_done ##1 (pin_cfg_q.status_sel == STAT_SEL_FOREGROUND_COMPLETE_FLAG && !fg_cal_start) |=> cal_state_output_pin;
  endproperty
  a_foreground_complete_flag: assert property (p_foreground_complete_flag) else $error("foreground done not shown on pin");

  property p_stopped;
    @(posedge hclk) disable iff (!hresetn)
    (bg_cal_resumed && !stopped_set) |=> !stopped_q;
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped flag not cleared on resume");

  property p_fg_stops;
    @(posedge hclk) disable iff (!hresetn)
    (fg_cal_done && !bg_enable_q) |=> stopped_q;
  endproperty
  a_fg_stops: assert property (p_fg_stops) else $error("stopped flag not set on foreground done");

  property p_lp_gate;
    @(posedge hclk) disable iff (!hresetn)
    !lp_active |=> lp_state == LP_IDLE && !core_sleep;
  endproperty
  a_lp_gate: assert property (p_lp_gate) else $error("low-power sequence ran while disabled");

  property p_fuse_gain;
    @(posedge hclk) disable iff (!hresetn)
    fuse_load |=> gain_trim == $past(fuse_gain) && bandgap_trim == $past(fuse_bandgap);
  endproperty
  a_fuse_gain: assert property (p_fuse_gain) else $error("trim not loaded from fuse store");

endmodule
`default_nettype wire

// ### verification/tb_cal_trigger_lowpower_ctrl.sv
// Self-checking testbench of the calibration trigger and low-power control block
`timescale 1ns/1ps
`default_nettype none
module tb_cal_trigger_lowpower_ctrl import cal_ctrl_pkg::*; ;
  // Short sleep and wake tables keep each timed low-power run under a hundred cycles
  localparam sleep_table_type SLP = {41'd80, 41'd70, 41'd60, 41'd50, 41'd40, 41'd30, 41'd20, 41'd10};
  localparam wake_table_type WK = {41'd12, 41'd8, 41'd6, 41'd4};
  localparam logic [6:0] E_FGS = 7'h01;
  localparam logic [6:0] E_FGD = 7'h02;
  localparam logic [6:0] E_STP = 7'h04;
  localparam logic [6:0] E_RES = 7'h08;
  localparam logic [6:0] E_OFF = 7'h10;
  localparam logic [6:0] E_LCD = 7'h20;
  localparam logic [6:0] E_FUS = 7'h40;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, cal_state_output_pin, cal_trigger, background_cal_enable;
  logic core_sleep, core_cal_start, irq;
  logic [31:0] hrdata;
  logic [7:0] gain_trim, term_a_trim;
  logic [3:0] bandgap_trim;
  logic cal_trigger_input_pin = 1'b0;
  logic alarm = 1'b0;
  logic [6:0] ev = 7'h0;
  logic [7:0] fuse_gain = 8'h0;
  logic [3:0] fuse_bandgap = 4'h0;
  logic [7:0] fuse_term_a = 8'h0;
  int fails = 0;
  int compares = 0;

  cal_trigger_lowpower_ctrl #(.SLEEP_CYCLES(SLP), .WAKE_CYCLES(WK)) i_cal_trigger_lowpower_ctrl (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .cal_trigger_input_pin, .alarm, .fg_cal_start(ev[0]), .fg_cal_done(ev[1]),
    .bg_cal_stopped(ev[2]), .bg_cal_resumed(ev[3]), .core_offline(ev[4]), .lp_cal_done(ev[5]),
    .fuse_load(ev[6]), .fuse_gain, .fuse_bandgap, .fuse_term_a, .cal_state_output_pin, .cal_trigger,
    .background_cal_enable, .core_sleep, .core_cal_start, .gain_trim, .bandgap_trim, .term_a_trim, .irq);

  always #25 hclk = ~hclk;

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic pulse(input logic [6:0] m);
    ev <= m;
    @(posedge hclk);
    ev <= 7'h0;
  endtask

  // Address phase held until hready is seen high, then data phase held likewise
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [31:0] exp, input string msg);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk(hrdata, exp, msg);
    chk({31'h0, hresp}, 32'h0, "response");
  endtask

  task automatic t_reset;
    chk({31'h0, cal_trigger}, 32'h1, "trigger after reset");
    rc(IDX_PIN_CFG, 32'h0, "pin cfg reset");
    rc(IDX_SOFT_TRIG, 32'h1, "soft trig reset");
    rc(IDX_LP, 32'h88, "lp reset");
    rc(IDX_GAIN, 32'h0, "gain reset");
    rc(IDX_BANDGAP, 32'h0, "bandgap reset");
    wr(8'h01, 32'hFF);
    rc(8'h01, 32'h0, "unmapped");
    wr(IDX_PIN_CFG, 32'hFF);
    rc(IDX_PIN_CFG, 32'h7, "pin cfg reserved");
    wr(IDX_LP, 32'hFF);
    rc(IDX_LP, 32'hFB, "lp reserved");
    wr(IDX_LP, 32'h88);
  endtask

  task automatic t_trig;
    wr(IDX_PIN_CFG, 32'h0);
    cal_trigger_input_pin <= 1'b1;
    wr(IDX_SOFT_TRIG, 32'h0);
    cyc(2);
    chk({31'h0, cal_trigger}, 32'h0, "soft source low");
    wr(IDX_SOFT_TRIG, 32'h1);
    cal_trigger_input_pin <= 1'b0;
    cyc(2);
    chk({31'h0, cal_trigger}, 32'h1, "soft source high");
    wr(IDX_PIN_CFG, 32'h1);
    cyc(2);
    chk({31'h0, cal_trigger}, 32'h0, "pin source low");
    cal_trigger_input_pin <= 1'b1;
    cyc(1);
    chk({31'h0, cal_trigger}, 32'h0, "trigger registered");
    cyc(1);
    chk({31'h0, cal_trigger}, 32'h1, "pin source high");
    wr(IDX_SOFT_TRIG, 32'h0);
    cyc(2);
    chk({31'h0, cal_trigger}, 32'h1, "soft bit ignored");
  endtask

  // Expected pin level for each select code, indexed by code
  task automatic t_pin(input logic [3:0] e);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_PIN_CFG, 32'(s) << 1);
      cyc(2);
      chk({31'h0, cal_state_output_pin}, {31'h0, e[s]}, "status pin");
    end
  endtask

  task automatic t_status;
    wr(IDX_ENGINE, 32'h0);
    pulse(E_FGD);
    cyc(1);
    rc(IDX_STATUS, 32'h3, "done sets both flags");
    wr(IDX_ENGINE, 32'h1);
    cyc(1);
    chk({31'h0, background_cal_enable}, 32'h1, "engine enable");
    pulse(E_RES);
    cyc(1);
    rc(IDX_STATUS, 32'h1, "resume clears stopped");
    t_pin(4'b0001);
    alarm <= 1'b1;
    pulse(E_STP | E_FGS);
    cyc(1);
    rc(IDX_STATUS, 32'h2, "halt sets stopped");
    t_pin(4'b0110);
  endtask

  task automatic t_irq;
    wr(IDX_IRQ_MASK, 32'h1);
    wr(IDX_IRQ_STATUS, 32'hF);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq idle");
    pulse(E_FGD);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(IDX_IRQ_MASK, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rc(IDX_IRQ_STATUS, 32'h1, "irq status sticky");
    wr(IDX_IRQ_MASK, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(IDX_IRQ_STATUS, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask

  task automatic t_trim;
    wr(IDX_GAIN, 32'hA5);
    wr(IDX_BANDGAP, 32'hFF);
    rc(IDX_GAIN, 32'hA5, "gain rw");
    rc(IDX_BANDGAP, 32'hF, "bandgap rw");
    chk({24'h0, gain_trim}, 32'hA5, "gain out");
    fuse_gain <= 8'h3C;
    fuse_bandgap <= 4'h9;
    fuse_term_a <= 8'h5A;
    pulse(E_FUS);
    cyc(1);
    chk({24'h0, gain_trim}, 32'h3C, "gain fuse");
    chk({28'h0, bandgap_trim}, 32'h9, "bandgap fuse");
    chk({24'h0, term_a_trim}, 32'h5A, "term fuse");
    rc(IDX_GAIN, 32'h3C, "gain fuse read");
    rc(IDX_TERM_A, 32'h5A, "term read");
  endtask

  // Trigger is low here, so a trigger-driven sleep would end at once
  task automatic t_lp_timed(input logic [2:0] sc, input logic [1:0] wc);
    int n;
    int t;
    n = 0;
    t = int'(SLP[sc] + WK[wc]);
    wr(IDX_LP, {24'h0, sc, wc, 3'b001});
    pulse(E_OFF);
    while (core_cal_start !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk({31'h0, n == t + 1}, 32'h1, "timed sleep and settle");
    pulse(E_LCD);
  endtask

  task automatic t_lp;
    int n;
    n = 0;
    wr(IDX_ENGINE, 32'h0);
    wr(IDX_LP, 32'h89);
    pulse(E_OFF);
    cyc(3);
    chk({31'h0, core_sleep}, 32'h0, "needs background");
    wr(IDX_ENGINE, 32'h1);
    for (int s = 0; s < 8; s++) begin
      t_lp_timed(3'(s), 2'(s));
    end
    wr(IDX_SOFT_TRIG, 32'h1);
    wr(IDX_PIN_CFG, 32'h0);
    wr(IDX_LP, 32'h8B);
    pulse(E_OFF);
    cyc(100);
    chk({31'h0, core_sleep}, 32'h1, "asleep while trigger high");
    wr(IDX_SOFT_TRIG, 32'h0);
    while (core_cal_start !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk({31'h0, n == int'(WK[1]) + 3}, 32'h1, "woken by trigger low");
    pulse(E_LCD);
  endtask

  initial begin
    cyc(10);
    hresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_trig();
    t_status();
    t_irq();
    t_trim();
    t_lp();
    end_sim();
  end

  // Whole run needs under a thousand cycles; this cuts a hang short
  initial begin
    #(50 * 30000);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
